/* File: pkg/host_port_pkg.sv */
// Constants shared by the host port serial slave and its helpers
`default_nettype none

package host_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int unsigned ADDR_W         = 7;          // Register address width
  localparam int unsigned DATA_W         = 8;          // Data byte width
  localparam int unsigned REG_DEPTH      = 128;        // Registers reachable by 7-bit address
  localparam int unsigned BIT_CNT_W      = 3;          // Counts bits within one byte
  localparam logic [2:0]  BYTE_LAST_BIT  = 3'h7;       // Index of the eighth bit of a byte
  localparam int unsigned RW_FLAG_POS    = 7;          // Direction flag, first bit on the wire
  localparam logic        RW_WRITE       = 1'b0;       // Master writes to the device
  localparam logic        RW_READ        = 1'b1;       // Device returns data to the master

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses and field positions
  localparam logic [6:0]  INTERFACE_CONFIG_ADDR  = 7'h6B;
  localparam logic [6:0]  NONVOLATILE_CONFIG_ADDR = 7'h70;
  localparam logic [6:0]  PROBE_READ_ADDR        = 7'h7F;
  localparam int unsigned THREE_WIRE_SELECT_POS  = 0;
  localparam int unsigned SPI_LOCK_POS           = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [6:0]  ADDR_RESET     = 7'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [2:0]  BIT_CNT_RESET  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: {lock, chip select, clock, data}; idle chip select is high
  localparam int unsigned PIN_SYNC_W     = 4;
  localparam logic [3:0]  PIN_SYNC_RESET = 4'h4;
  localparam int unsigned PIN_LOCK_POS   = 3;
  localparam int unsigned PIN_CS_POS     = 2;
  localparam int unsigned PIN_SCK_POS    = 1;
  localparam int unsigned PIN_SDI_POS    = 0;

  // Frame sequencing
  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_CMD,
    FRAME_DATA
  } frame_state_t;

endpackage : host_port_pkg

`default_nettype wire

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module pin_sync
#(
  parameter int unsigned WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // pin_sync

`default_nettype wire

/* File: rtl/reg_store.sv */
// Register storage with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none

module reg_store
  import host_port_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic      [DATA_W-1:0] o_rd_data
);

  logic [DATA_W-1:0] mem [0:REG_DEPTH-1];
  logic [DATA_W-1:0] rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte write
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read, one cycle after the request
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      rd_data_reg <= DATA_RESET;
    end
    else if (i_rd_en)
    begin
      rd_data_reg <= mem[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_reg;

endmodule // reg_store

`default_nettype wire

/* File: rtl/host_port_protocol_select_spi.sv */
// Host port serial slave: protocol selection, 4/3-wire framing, auto-increment reads
`timescale 1ns/10ps
`default_nettype none

module host_port_protocol_select_spi
  import host_port_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_sck,
  input  wire logic              i_sdi,
  input  wire logic              i_nonvolatile_spi_lock,
  output logic                   o_sdi_out,
  output logic                   o_sdi_oe,
  output logic                   o_sdo,
  output logic                   o_sdo_oe,
  output logic                   o_spi_mode,
  output logic                   o_three_wire,
  output logic                   o_clock_idle_high,
  output logic                   o_frame_active,
  output logic                   o_wr_valid,
  output logic      [ADDR_W-1:0] o_wr_addr,
  output logic      [DATA_W-1:0] o_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PIN_SYNC_W-1:0] pins_sync;
  logic                  lock_s;
  logic                  cs_n_s;
  logic                  sck_s;
  logic                  sdi_s;
  logic                  cs_prev_reg;
  logic                  sck_prev_reg;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  spi_mode_reg;
  logic                  three_wire_reg;
  logic                  clock_idle_high_reg;
  frame_state_t          state_reg;
  logic [BIT_CNT_W-1:0]  bit_cnt_reg;
  logic [DATA_W-1:0]     rx_shift_reg;
  logic [DATA_W-1:0]     rx_byte;
  logic                  byte_done;
  logic                  rw_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic                  rd_req_reg;
  logic                  tx_load_reg;
  logic [DATA_W-1:0]     tx_shift_reg;
  logic [DATA_W-1:0]     rd_data;
  logic                  out_bit_reg;
  logic                  drive_reg;
  logic                  sdo_oe_reg;
  logic                  sdi_oe_reg;
  logic                  wr_valid_reg;
  logic [ADDR_W-1:0]     wr_addr_reg;
  logic [DATA_W-1:0]     wr_data_reg;
  logic                  frame_active_reg;
  logic                  store_wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation: every pin passes two flip-flops
  pin_sync #(
    .WIDTH       (PIN_SYNC_W),
    .RESET_VALUE (PIN_SYNC_RESET)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_nonvolatile_spi_lock, i_chip_select_n, i_sck, i_sdi}),
    .o_sync  (pins_sync)
  );

  assign lock_s = pins_sync[PIN_LOCK_POS];
  assign cs_n_s = pins_sync[PIN_CS_POS];
  assign sck_s  = pins_sync[PIN_SCK_POS];
  assign sdi_s  = pins_sync[PIN_SDI_POS];

  // Previous levels for edge detection, reset to the synchroniser idle levels
  always_ff @(posedge i_clock)
  begin
    cs_prev_reg  <= !i_rst_b || cs_n_s;
    sck_prev_reg <= i_rst_b && sck_s;
  end

  // frame edges
  // Clock edges count only inside a selected frame
  assign cs_fall  = cs_prev_reg & ~cs_n_s;
  assign cs_rise  = ~cs_prev_reg & cs_n_s;
  assign sck_rise = ~sck_prev_reg & sck_s & ~cs_n_s;
  assign sck_fall = sck_prev_reg & ~sck_s & ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol selection
  // two-wire default
  // nonvolatile lock
  // Sticky until reset: set by the first chip select rise or by the lock bit
  always_ff @(posedge i_clock)
  begin
    spi_mode_reg <= i_rst_b && (spi_mode_reg || cs_rise || lock_s);
  end

  // mode detection
  // Clock level just after chip select falls tells mode 11 from mode 00
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      clock_idle_high_reg <= 1'b0;
    end
    else if (cs_fall && spi_mode_reg)
    begin
      clock_idle_high_reg <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  // byte framing
  assign byte_done = sck_rise && (bit_cnt_reg == BYTE_LAST_BIT);
  assign rx_byte   = {rx_shift_reg[DATA_W-2:0], sdi_s};

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b || cs_n_s || !spi_mode_reg)
    begin
      state_reg <= FRAME_IDLE;
    end
    else
    begin
      unique case (state_reg)
        FRAME_IDLE: state_reg <= cs_fall ? FRAME_CMD : FRAME_IDLE;
        FRAME_CMD:  state_reg <= byte_done ? FRAME_DATA : FRAME_CMD;
        FRAME_DATA: state_reg <= FRAME_DATA;
      endcase
    end
  end

  // sample on rising
  // Bit counter and receive shifter advance on each rising clock edge outside FRAME_IDLE
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      bit_cnt_reg  <= BIT_CNT_RESET;
      rx_shift_reg <= DATA_RESET;
    end
    else if (state_reg == FRAME_IDLE)
    begin
      bit_cnt_reg  <= BIT_CNT_RESET;
      rx_shift_reg <= DATA_RESET;
    end
    else if (sck_rise)
    begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= rx_byte;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      rw_reg   <= RW_WRITE;
      addr_reg <= ADDR_RESET;
    end
    else if (byte_done && state_reg == FRAME_CMD)
    begin
      rw_reg   <= rx_byte[RW_FLAG_POS];
      addr_reg <= rx_byte[ADDR_W-1:0];
    end
    else if (byte_done && state_reg == FRAME_DATA)
    begin
      addr_reg <= addr_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access
  // data write
  // Completed data byte of a write frame goes to the addressed register
  assign store_wr_en = byte_done && (state_reg == FRAME_DATA) && (rw_reg == RW_WRITE);

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      wr_valid_reg <= 1'b0;
      wr_addr_reg  <= ADDR_RESET;
      wr_data_reg  <= DATA_RESET;
    end
    else
    begin
      wr_valid_reg <= store_wr_en;
      if (store_wr_en)
      begin
        wr_addr_reg <= addr_reg;
        wr_data_reg <= rx_byte;
      end
    end
  end

  // wiring select
  // Select bit tracks every write to the interface configuration register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      three_wire_reg <= 1'b0;
    end
    else if (store_wr_en && addr_reg == INTERFACE_CONFIG_ADDR)
    begin
      three_wire_reg <= rx_byte[THREE_WIRE_SELECT_POS];
    end
  end

  // next read
  // Read request after the command byte and after each returned byte
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      rd_req_reg  <= 1'b0;
      tx_load_reg <= 1'b0;
    end
    else
    begin
      rd_req_reg  <= (byte_done && state_reg == FRAME_CMD && rx_byte[RW_FLAG_POS] == RW_READ)
                  || (byte_done && state_reg == FRAME_DATA && rw_reg == RW_READ);
      tx_load_reg <= rd_req_reg;
    end
  end

  reg_store u_reg_store (
    .i_clock   (i_clock),
    .i_rst_b   (i_rst_b),
    .i_wr_en   (store_wr_en),
    .i_wr_addr (addr_reg),
    .i_wr_data (rx_byte),
    .i_rd_en   (rd_req_reg),
    .i_rd_addr (addr_reg),
    .o_rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data output
  // data read
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      tx_shift_reg <= DATA_RESET;
      out_bit_reg  <= 1'b0;
    end
    else if (tx_load_reg)
    begin
      tx_shift_reg <= rd_data;
    end
    else if (sck_fall && state_reg == FRAME_DATA && rw_reg == RW_READ)
    begin
      out_bit_reg  <= tx_shift_reg[DATA_W-1];
      tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
    end
  end

  // drive window
  // Drive starts at first falling edge of read data and ends with the frame
  always_ff @(posedge i_clock)
  begin
    drive_reg <= i_rst_b && (state_reg == FRAME_DATA) && (rw_reg == RW_READ) && !cs_n_s
              && (drive_reg || sck_fall);
  end

  // shared line
  // Only one pin is enabled, chosen by the wiring select
  always_ff @(posedge i_clock)
  begin
    sdo_oe_reg <= i_rst_b && drive_reg && !three_wire_reg && !cs_n_s;
    sdi_oe_reg <= i_rst_b && drive_reg && three_wire_reg && !cs_n_s;
  end

  // Frame status for the rest of the chip
  always_ff @(posedge i_clock)
  begin
    frame_active_reg <= i_rst_b && (state_reg != FRAME_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign o_sdo             = out_bit_reg;
  assign o_sdi_out         = out_bit_reg;
  assign o_sdo_oe          = sdo_oe_reg;
  assign o_sdi_oe          = sdi_oe_reg;
  assign o_spi_mode        = spi_mode_reg;
  assign o_three_wire      = three_wire_reg;
  assign o_clock_idle_high = clock_idle_high_reg;
  assign o_frame_active    = frame_active_reg;
  assign o_wr_valid        = wr_valid_reg;
  assign o_wr_addr         = wr_addr_reg;
  assign o_wr_data         = wr_data_reg;

endmodule // host_port_protocol_select_spi

`default_nettype wire

/* File: dv/host_port_asserts.sv */
// Concurrent checks on the host port serial slave
`timescale 1ns/10ps
`default_nettype none

module host_port_asserts
  import host_port_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_rst_b,
  input wire logic              i_chip_select_n,
  input wire logic              i_sck,
  input wire logic              i_nonvolatile_spi_lock,
  input wire logic              o_sdo,
  input wire logic              o_sdo_oe,
  input wire logic              o_sdi_oe,
  input wire logic              o_spi_mode,
  input wire logic              o_three_wire,
  input wire logic              o_wr_valid,
  input wire logic [ADDR_W-1:0] o_wr_addr,
  input wire logic [DATA_W-1:0] o_wr_data
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////
  // Protocol selection
  mode_sticky_a:
    assert property (o_spi_mode |=> o_spi_mode) else $error("spi mode lost");
  lock_forces_a:
    assert property (i_nonvolatile_spi_lock [*6] |-> o_spi_mode) else $error("lock ignored");
  two_wire_quiet_a:
    assert property (!o_spi_mode |-> !(o_sdo_oe || o_sdi_oe || o_wr_valid)) else $error("active in two-wire");
  // Pin drive
  drive_select_a:
    assert property (o_sdo_oe || o_sdi_oe |-> o_sdi_oe == o_three_wire && o_sdo_oe != o_three_wire)
      else $error("wrong data pin driven");
  cs_release_a:
    assert property (i_chip_select_n [*6] |-> !(o_sdo_oe || o_sdi_oe)) else $error("pin held after frame");
  fall_launch_a:
    assert property (o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo) |-> !(i_sck || $past(i_sck)))
      else $error("data changed off falling clock");
  // Write side
  wr_pulse_a:
    assert property (o_wr_valid |=> !o_wr_valid) else $error("write pulse too long");
  three_wire_set_a:
    assert property ($changed(o_three_wire) |-> (o_wr_valid || $past(o_wr_valid))
      && o_wr_addr == INTERFACE_CONFIG_ADDR && o_three_wire == o_wr_data[0]) else $error("wiring changed");
  cover property (o_wr_valid && o_three_wire);
  cover property ($rose(o_sdi_oe));
  cover property ($rose(o_sdo_oe));
endmodule // host_port_asserts

`default_nettype wire

/* File: dv/spi_master_model.sv */
// Serial master model for the host port, with released-line behaviour
`timescale 1ns/10ps
`default_nettype none

module spi_master_model
(
  input  wire logic i_clock,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  input  wire logic i_sdi_out,
  input  wire logic i_sdi_oe,
  output var logic  o_cs_n,
  output var logic  o_sck,
  output var logic  o_sdi
);
  logic       three_wire = 1'b0;
  logic       cpol = 1'b1;
  logic       m_oe = 1'b0;
  logic       m_bit = 1'b0;
  logic       junk = 1'b0;
  logic       oe_seen;
  logic [7:0] rx_byte;
  logic [7:0] tx_q[$];
  event       got_byte;

  ////////////////////////////////////////
  // Released lines toggle every cycle
  always @(negedge i_clock) junk <= ~junk;
  assign o_sdi = m_oe ? m_bit : (i_sdi_oe === 1'b1 ? i_sdi_out : junk);
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b1;
  end

  task automatic shift(input logic b, input logic drive, output logic s);
    @(negedge i_clock);
    o_sck = 1'b0;
    m_bit = b;
    m_oe = drive;
    repeat (5) @(negedge i_clock);
    s = three_wire ? o_sdi : (i_sdo_oe === 1'b1 ? i_sdo : junk);
    oe_seen |= i_sdo_oe;
    o_sck = 1'b1;
    repeat (2) @(negedge i_clock);
  endtask

  task automatic frame(input logic rw, input logic [6:0] a, input int n);
    logic [7:0] d;
    logic       s;
    d = {rw, a};
    oe_seen = 1'b0;
    @(negedge i_clock);
    o_sck = cpol;
    repeat (4) @(negedge i_clock);
    o_cs_n = 1'b0;
    repeat (2) @(negedge i_clock);
    for (int i = 7; i >= 0; i--) shift(d[i], 1'b1, s);
    for (int k = 0; k < n; k++)
    begin
      d = rw ? 8'h00 : tx_q.pop_front();
      for (int i = 7; i >= 0; i--)
      begin
        shift(d[i], !(rw && three_wire), s);
        rx_byte[i] = s;
      end
      if (rw) ->got_byte;
    end
    @(negedge i_clock);
    o_sck = cpol;
    repeat (3) @(negedge i_clock);
    o_cs_n = 1'b1;
    m_oe = 1'b0;
  endtask
endmodule // spi_master_model

`default_nettype wire

/* File: dv/host_port_protocol_select_spi_test.sv */
// Self-checking bench for the host port serial slave
`timescale 1ns/10ps
`default_nettype none

module host_port_protocol_select_spi_test
  import host_port_pkg::*;
;
  logic        i_clock;
  logic        i_rst_b;
  logic        lock;
  logic        cs_n;
  logic        sck;
  logic        sdi;
  logic        sdi_out;
  logic        sdi_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        spi_mode;
  logic        three_wire;
  logic        idle_high;
  logic        frame_active;
  logic        wr_valid;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [14:0] exp_wr[$];
  logic [7:0]  exp_rd[$];
  logic [7:0]  mem[128];
  logic [31:0] seed = 32'h0001_5a43;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  host_port_protocol_select_spi i_host_port_protocol_select_spi
  (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_chip_select_n(cs_n), .i_sck(sck), .i_sdi(sdi),
    .i_nonvolatile_spi_lock(lock), .o_sdi_out(sdi_out), .o_sdi_oe(sdi_oe), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_spi_mode(spi_mode), .o_three_wire(three_wire), .o_clock_idle_high(idle_high),
    .o_frame_active(frame_active), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data)
  );
  spi_master_model i_spi_master_model
  (
    .i_clock(i_clock), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .i_sdi_out(sdi_out), .i_sdi_oe(sdi_oe),
    .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi)
  );

  ////////////////////////////////////////
  // Clock, 50 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic lk);
    @(negedge i_clock);
    i_rst_b = 1'b0;
    lock = lk;
    repeat (4) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (8) @(negedge i_clock);
  endtask

  // Write n bytes from a, first one given, noting each expected store
  task automatic wr(input logic [6:0] a, input int n, input logic [7:0] first);
    logic [7:0] d;
    for (int k = 0; k < n; k++)
    begin
      d = (k == 0) ? first : rnd();
      mem[a + 7'(k)] = d;
      exp_wr.push_back({a + 7'(k), d});
      i_spi_master_model.tx_q.push_back(d);
    end
    i_spi_master_model.frame(RW_WRITE, a, n);
  endtask

  task automatic rd(input logic [6:0] a, input int n);
    for (int k = 0; k < n; k++) exp_rd.push_back(mem[a + 7'(k)]);
    i_spi_master_model.frame(RW_READ, a, n);
  endtask

  // Stored bytes against the oldest note, sampled where settled; timeout
  always @(negedge i_clock)
  begin
    cycles++;
    if (wr_valid === 1'b1)
      check({wr_addr, wr_data}, exp_wr.size() ? exp_wr.pop_front() : 15'h7fff);
    if (cycles == 30000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Returned bytes against the oldest note
  // Only the probe frame, sent in two-wire mode, carries no note
  always @(i_spi_master_model.got_byte)
  begin
    if (exp_rd.size())
    begin
      check(i_spi_master_model.rx_byte, exp_rd.pop_front());
      check(frame_active, 1'b1);
    end
    else
      check(frame_active, 1'b0);
  end

  // Main sequence
  initial
  begin
    i_rst_b = 1'b0;
    lock = 1'b0;
    do_reset(1'b0);
    check(spi_mode, 1'b0);
    i_spi_master_model.frame(RW_READ, PROBE_READ_ADDR, 1);
    repeat (4) @(negedge i_clock);
    check(spi_mode, 1'b1);
    wr(7'h10, 1, rnd());
    check(i_spi_master_model.oe_seen, 1'b0);
    wr(7'h20, 3, rnd());
    i_spi_master_model.cpol = 1'b0;
    rd(7'h20, 3);
    check(idle_high, 1'b0);
    check(i_spi_master_model.oe_seen, 1'b1);
    i_spi_master_model.cpol = 1'b1;
    rd(7'h10, 1);
    check(idle_high, 1'b1);
    wr(INTERFACE_CONFIG_ADDR, 1, 8'h01);
    repeat (4) @(negedge i_clock);
    check(three_wire, 1'b1);
    i_spi_master_model.three_wire = 1'b1;
    wr(7'h30, 2, rnd());
    rd(7'h30, 2);
    check(i_spi_master_model.oe_seen, 1'b0);
    do_reset(1'b1);
    i_spi_master_model.three_wire = 1'b0;
    check(spi_mode, 1'b1);
    check(three_wire, 1'b0);
    wr(7'h45, 1, rnd());
    rd(7'h45, 1);
    check(15'(exp_rd.size() + exp_wr.size()), 15'h0000);
    tally_and_finish();
  end
endmodule // host_port_protocol_select_spi_test

bind host_port_protocol_select_spi host_port_asserts i_host_port_asserts (.*);

`default_nettype wire
